// ### objdict_pkg.sv
package objdict_pkg;
    localparam logic [15:0] IDX_DEVICE_TYPE = 16'h1000;
    localparam logic [15:0] IDX_FAULT = 16'h1001;
    localparam logic [15:0] IDX_NAME = 16'h1008;
    localparam logic [15:0] IDX_HW_VER = 16'h1009;
    localparam logic [15:0] IDX_SW_VER = 16'h100a;
    localparam logic [15:0] IDX_STORE = 16'h1010;
    localparam logic [15:0] IDX_RESTORE = 16'h1011;
    localparam logic [15:0] IDX_IDENTITY = 16'h1018;
    localparam logic [15:0] IDX_APP_BASE = 16'h6000;
    localparam int APP_SLOTS = 4;
    localparam logic [1:0] APP_SPEED_SLOT = 2'h0;
    localparam logic [7:0] SUB_ALL = 8'h01;
    localparam logic [7:0] SUB_COMM = 8'h02;
    localparam logic [7:0] SUB_APP = 8'h03;
    localparam logic [7:0] STORE_HIGHEST = 8'h03;
    localparam logic [7:0] RESTORE_HIGHEST = 8'h03;
    localparam logic [7:0] IDENTITY_HIGHEST = 8'h04;
    localparam logic [31:0] SIG_SAVE = 32'h65766173;
    localparam logic [31:0] SIG_LOAD = 32'h64616f6c;
    localparam logic [15:0] PROFILE_NUMBER = 16'h0192;
    localparam logic [7:0] TYPE_SERVO = 8'h2a;
    localparam logic [7:0] TYPE_CONVERTER = 8'h29;
    localparam logic [7:0] MODE_BITS = 8'h00;
    localparam logic [7:0] SETUP_MOTION = 8'h40;
    localparam logic [7:0] FAULT_ANY = 8'h01;
    localparam logic [31:0] STORE_CAPS = 32'h00000001;
    localparam logic [31:0] APP_DEFAULT = 32'h00000000;
    localparam logic [39:0] SECONDS_PER_MINUTE = 40'h000000003c;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RELOAD = 2'b01,
        ST_STORE = 2'b10
    } state_t;
endpackage : objdict_pkg

// ### nv_param_store.sv
`timescale 1ns/1ps
module nv_param_store (
    input wire logic core_clk,
    input wire logic nvEraseN,
    input wire logic wrEn,
    input wire logic [1:0] wrSlot,
    input wire logic [31:0] wrData,
    input wire logic [1:0] rdSlot,
    output logic [31:0] rdData,
    output logic rdValid
);
    typedef struct packed {
        logic [objdict_pkg::APP_SLOTS-1:0][31:0] mem;
        logic [objdict_pkg::APP_SLOTS-1:0] valid;
    } nv_t;

    nv_t cur;
    nv_t next_cur;

    // Erase only on its own reset so the core reset models a power cycle
    always_comb begin
        next_cur = cur;
        if (wrEn) begin
            next_cur.mem[wrSlot] = wrData;
            next_cur.valid[wrSlot] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nvEraseN) begin
        if (!nvEraseN) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdData = cur.mem[rdSlot];
    assign rdValid = cur.valid[rdSlot];
endmodule : nv_param_store

// ### object_dictionary_store_restore.sv
`timescale 1ns/1ps
module object_dictionary_store_restore #(
    parameter logic [31:0] MAKER_CODE = 32'h00000a5a, // Arbitrary value
    parameter logic [31:0] PART_CODE = 32'h00000001,
    parameter logic [31:0] SYSTEM_REVISION = 32'h00000001,
    parameter logic [31:0] UNIT_SERIAL = 32'h00000001,
    parameter logic [31:0] NAME_TEXT = 32'h4a424f44,
    parameter logic [31:0] HW_TEXT = 32'h31305748,
    parameter logic [31:0] SW_TEXT = 32'h302e3176
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic nvEraseN,
    input wire logic sdoReq,
    input wire logic sdoWrite,
    input wire logic [15:0] sdoIndex,
    input wire logic [7:0] sdoSubIndex,
    input wire logic [31:0] sdoWrData,
    output logic sdoReady,
    output logic sdoAck,
    output logic sdoAbort,
    output logic [31:0] sdoRdData,
    input wire logic legacyFirmware,
    input wire logic [7:0] driveSetup,
    input wire logic deviceFault,
    input wire logic [7:0] faultCode,
    input wire logic [7:0] pole_pair_count,
    output logic driveParamWr,
    output logic [1:0] driveParamSlot,
    output logic [31:0] driveParamData,
    output logic commStorePulse,
    output logic commRestorePulse
);
    typedef struct packed {
        objdict_pkg::state_t state;
        logic [1:0] ptr;
        logic [objdict_pkg::APP_SLOTS-1:0][31:0] app;
        logic ack;
        logic abort;
        logic [31:0] rdData;
        logic drvWr;
        logic [1:0] drvSlot;
        logic [31:0] drvData;
        logic commStore;
        logic commRestore;
    } regs_t;

    localparam regs_t REGS_RESET = '{
        state: objdict_pkg::ST_RELOAD,
        ptr: 2'h0,
        app: '0,
        ack: 1'b0,
        abort: 1'b0,
        rdData: 32'h00000000,
        drvWr: 1'b0,
        drvSlot: 2'h0,
        drvData: 32'h00000000,
        commStore: 1'b0,
        commRestore: 1'b0
    };

    regs_t cur;
    regs_t next_cur;
    logic take;
    logic isApp;
    logic [1:0] appSlot;
    logic [7:0] typeField;
    logic [31:0] deviceType;
    logic [7:0] faultSummary;
    logic nvWrEn;
    logic [1:0] nvRdSlot;
    logic [31:0] nvRdData;
    logic nvRdValid;

    // Speed objects are rpm; the drive wants frequency
    function automatic logic [31:0] driveValue(input logic [1:0] slot, input logic [31:0] data,
                                               input logic [7:0] pp);
        logic [39:0] prod;
        prod = 40'({8'h00, data} * {32'h00000000, pp});
        if (slot == objdict_pkg::APP_SPEED_SLOT) begin
            driveValue = 32'(prod / objdict_pkg::SECONDS_PER_MINUTE);
        end else begin
            driveValue = data;
        end
    endfunction : driveValue

    // Legacy builds decide the type from the drive setup
    assign typeField = (legacyFirmware && driveSetup != objdict_pkg::SETUP_MOTION) ?
                       objdict_pkg::TYPE_CONVERTER : objdict_pkg::TYPE_SERVO;
    assign deviceType = {objdict_pkg::MODE_BITS, typeField, objdict_pkg::PROFILE_NUMBER};
    // A fault with a zero code must still read nonzero
    assign faultSummary = !deviceFault ? 8'h00 :
                          (faultCode != 8'h00 ? faultCode : objdict_pkg::FAULT_ANY);

    assign take = sdoReq && sdoReady;
    assign isApp = (sdoIndex[15:2] == objdict_pkg::IDX_APP_BASE[15:2]) && sdoSubIndex == 8'h00;
    assign appSlot = sdoIndex[1:0];
    assign nvWrEn = cur.state == objdict_pkg::ST_STORE;
    assign nvRdSlot = cur.ptr;

    nv_param_store u_nv (
        .core_clk(core_clk),
        .nvEraseN(nvEraseN),
        .wrEn(nvWrEn),
        .wrSlot(cur.ptr),
        .wrData(cur.app[cur.ptr]),
        .rdSlot(nvRdSlot),
        .rdData(nvRdData),
        .rdValid(nvRdValid)
    );

    always_comb begin
        next_cur = cur;
        next_cur.ack = 1'b0;
        next_cur.abort = 1'b0;
        next_cur.drvWr = 1'b0;
        next_cur.commStore = 1'b0;
        next_cur.commRestore = 1'b0;
        case (cur.state)
            objdict_pkg::ST_RELOAD: begin
                // Only saved slots reach the drive; unsaved ones keep the zero that reset loaded
                if (nvRdValid) begin
                    next_cur.app[cur.ptr] = nvRdData;
                    next_cur.drvWr = 1'b1;
                    next_cur.drvSlot = cur.ptr;
                    next_cur.drvData = driveValue(cur.ptr, nvRdData, pole_pair_count);
                end
                next_cur.ptr = 2'(cur.ptr + 2'h1);
                if (cur.ptr == 2'(objdict_pkg::APP_SLOTS - 1)) begin
                    next_cur.state = objdict_pkg::ST_IDLE;
                end
            end
            objdict_pkg::ST_STORE: begin
                next_cur.ptr = 2'(cur.ptr + 2'h1);
                if (cur.ptr == 2'(objdict_pkg::APP_SLOTS - 1)) begin
                    next_cur.state = objdict_pkg::ST_IDLE;
                end
            end
            default: begin
                if (take) begin
                    next_cur.ack = 1'b1;
                    next_cur.rdData = 32'h00000000;
                    if (sdoWrite) begin
                        if (sdoIndex == objdict_pkg::IDX_STORE &&
                            sdoSubIndex >= objdict_pkg::SUB_ALL && sdoSubIndex <= objdict_pkg::SUB_APP) begin
                            if (sdoWrData != objdict_pkg::SIG_SAVE) begin
                                next_cur.abort = 1'b1;
                            end else begin
                                if (sdoSubIndex != objdict_pkg::SUB_APP) begin
                                    next_cur.commStore = 1'b1;
                                end
                                if (sdoSubIndex != objdict_pkg::SUB_COMM) begin
                                    next_cur.state = objdict_pkg::ST_STORE;
                                    next_cur.ptr = 2'h0;
                                end
                            end
                        end else if (sdoIndex == objdict_pkg::IDX_RESTORE &&
                            sdoSubIndex >= objdict_pkg::SUB_ALL && sdoSubIndex <= objdict_pkg::SUB_APP) begin
                            if (sdoWrData != objdict_pkg::SIG_LOAD) begin
                                next_cur.abort = 1'b1;
                            end else begin
                                if (sdoSubIndex != objdict_pkg::SUB_APP) begin
                                    next_cur.commRestore = 1'b1;
                                end
                                if (sdoSubIndex != objdict_pkg::SUB_COMM) begin
                                    next_cur.app = '0;
                                    for (int i = 0; i < objdict_pkg::APP_SLOTS; i++) begin
                                        next_cur.app[i] = objdict_pkg::APP_DEFAULT;
                                    end
                                end
                            end
                        end else if (isApp) begin
                            next_cur.app[appSlot] = sdoWrData;
                            next_cur.drvWr = 1'b1;
                            next_cur.drvSlot = appSlot;
                            next_cur.drvData = driveValue(appSlot, sdoWrData, pole_pair_count);
                        end else begin
                            next_cur.abort = 1'b1;
                        end
                    end else begin
                        if (sdoIndex == objdict_pkg::IDX_DEVICE_TYPE && sdoSubIndex == 8'h00) begin
                            next_cur.rdData = deviceType;
                        end else if (sdoIndex == objdict_pkg::IDX_FAULT && sdoSubIndex == 8'h00) begin
                            next_cur.rdData = {24'h000000, faultSummary};
                        end else if (sdoIndex == objdict_pkg::IDX_NAME && sdoSubIndex == 8'h00) begin
                            next_cur.rdData = NAME_TEXT;
                        end else if (sdoIndex == objdict_pkg::IDX_HW_VER && sdoSubIndex == 8'h00) begin
                            next_cur.rdData = HW_TEXT;
                        end else if (sdoIndex == objdict_pkg::IDX_SW_VER && sdoSubIndex == 8'h00) begin
                            next_cur.rdData = SW_TEXT;
                        end else if (sdoIndex == objdict_pkg::IDX_STORE && sdoSubIndex == 8'h00) begin
                            next_cur.rdData = {24'h000000, objdict_pkg::STORE_HIGHEST};
                        end else if (sdoIndex == objdict_pkg::IDX_RESTORE && sdoSubIndex == 8'h00) begin
                            next_cur.rdData = {24'h000000, objdict_pkg::RESTORE_HIGHEST};
                        end else if ((sdoIndex == objdict_pkg::IDX_STORE ||
                                      sdoIndex == objdict_pkg::IDX_RESTORE) &&
                                     sdoSubIndex <= objdict_pkg::SUB_APP) begin
                            next_cur.rdData = objdict_pkg::STORE_CAPS;
                        end else if (sdoIndex == objdict_pkg::IDX_IDENTITY && sdoSubIndex == 8'h00) begin
                            next_cur.rdData = {24'h000000, objdict_pkg::IDENTITY_HIGHEST};
                        end else if (sdoIndex == objdict_pkg::IDX_IDENTITY && sdoSubIndex == 8'h01) begin
                            next_cur.rdData = MAKER_CODE;
                        end else if (sdoIndex == objdict_pkg::IDX_IDENTITY && sdoSubIndex == 8'h02) begin
                            next_cur.rdData = PART_CODE;
                        end else if (sdoIndex == objdict_pkg::IDX_IDENTITY && sdoSubIndex == 8'h03) begin
                            next_cur.rdData = SYSTEM_REVISION;
                        end else if (sdoIndex == objdict_pkg::IDX_IDENTITY && sdoSubIndex == 8'h04) begin
                            next_cur.rdData = UNIT_SERIAL;
                        end else if (isApp) begin
                            next_cur.rdData = cur.app[appSlot];
                        end else begin
                            next_cur.abort = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= REGS_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // Requests wait during reload and store so the copy is never torn
    assign sdoReady = cur.state == objdict_pkg::ST_IDLE;
    assign sdoAck = cur.ack;
    assign sdoAbort = cur.abort;
    assign sdoRdData = cur.rdData;
    assign driveParamWr = cur.drvWr;
    assign driveParamSlot = cur.drvSlot;
    assign driveParamData = cur.drvData;
    assign commStorePulse = cur.commStore;
    assign commRestorePulse = cur.commRestore;

    property p_type_field;
        @(posedge core_clk) disable iff (!rstn)
        deviceType[31:24] == 8'h00 && deviceType[15:0] == 16'h0192 &&
        deviceType[23:16] == ((legacyFirmware && driveSetup != 8'h40) ? 8'h29 : 8'h2a);
    endproperty
    a_type_field: assert property (p_type_field) else $error("device type field wrong");

    property p_fault;
        @(posedge core_clk) disable iff (!rstn)
        take && !sdoWrite && sdoIndex == 16'h1001 && sdoSubIndex == 8'h00 |=>
        ((sdoRdData != 32'h0) == $past(deviceFault)) && !sdoAbort;
    endproperty
    a_fault: assert property (p_fault) else $error("fault summary wrong");

    property p_store_go;
        @(posedge core_clk) disable iff (!rstn)
        take && sdoWrite && sdoIndex == 16'h1010 && sdoSubIndex == 8'h03 && sdoWrData == 32'h65766173 |=>
        nvWrEn [*4] ##1 sdoReady;
    endproperty
    a_store_go: assert property (p_store_go) else $error("store did not copy four slots");

    property p_store_bad;
        @(posedge core_clk) disable iff (!rstn)
        take && sdoWrite && sdoIndex == 16'h1010 && sdoSubIndex inside {[8'h01:8'h03]} &&
        sdoWrData != 32'h65766173 |=> sdoAck && sdoAbort && !nvWrEn && !commStorePulse;
    endproperty
    a_store_bad: assert property (p_store_bad) else $error("bad save not aborted");

    property p_load_bad;
        @(posedge core_clk) disable iff (!rstn)
        take && sdoWrite && sdoIndex == 16'h1011 && sdoSubIndex inside {[8'h01:8'h03]} &&
        sdoWrData != 32'h64616f6c |=> sdoAbort && $stable(cur.app);
    endproperty
    a_load_bad: assert property (p_load_bad) else $error("bad load changed objects");

    property p_load_go;
        @(posedge core_clk) disable iff (!rstn)
        take && sdoWrite && sdoIndex == 16'h1011 && sdoSubIndex == 8'h03 && sdoWrData == 32'h64616f6c |=>
        cur.app == '0 && !sdoAbort;
    endproperty
    a_load_go: assert property (p_load_go) else $error("restore left objects set");

    property p_reload;
        @(posedge core_clk) disable iff (!rstn)
        cur.state == objdict_pkg::ST_RELOAD && nvRdValid |=> driveParamWr && driveParamSlot == $past(cur.ptr);
    endproperty
    a_reload: assert property (p_reload) else $error("saved value not reloaded");

    property p_unsaved;
        @(posedge core_clk) disable iff (!rstn)
        cur.state == objdict_pkg::ST_RELOAD && !nvRdValid |=> !driveParamWr;
    endproperty
    a_unsaved: assert property (p_unsaved) else $error("unsaved slot pushed to drive");

    property p_convert;
        @(posedge core_clk) disable iff (!rstn)
        take && sdoWrite && isApp && appSlot == 2'h0 |=>
        driveParamData == 32'(({8'h00, $past(sdoWrData)} * {32'h0, $past(pole_pair_count)}) / 40'd60);
    endproperty
    a_convert: assert property (p_convert) else $error("speed conversion wrong");

    property p_highest;
        @(posedge core_clk) disable iff (!rstn)
        take && !sdoWrite && sdoIndex == 16'h1018 && sdoSubIndex == 8'h00 |=> sdoRdData == 32'h4;
    endproperty
    a_highest: assert property (p_highest) else $error("identity highest sub-index wrong");

    property p_store_highest;
        @(posedge core_clk) disable iff (!rstn)
        take && !sdoWrite && sdoIndex == 16'h1010 && sdoSubIndex == 8'h00 |=> sdoRdData == 32'h3;
    endproperty
    a_store_highest: assert property (p_store_highest) else $error("store highest sub-index wrong");

    property p_restore_highest;
        @(posedge core_clk) disable iff (!rstn)
        take && !sdoWrite && sdoIndex == 16'h1011 && sdoSubIndex == 8'h00 |=> sdoRdData == 32'h3;
    endproperty
    a_restore_highest: assert property (p_restore_highest) else $error("restore highest wrong");

    // Sub-index 2 acts on communication data only, so no copy cycles follow
    property p_comm_store;
        @(posedge core_clk) disable iff (!rstn)
        take && sdoWrite && sdoIndex == 16'h1010 && sdoSubIndex == 8'h02 && sdoWrData == 32'h65766173 |=>
        sdoAck && !sdoAbort && commStorePulse && sdoReady;
    endproperty
    a_comm_store: assert property (p_comm_store) else $error("comm store wrong");

    property p_comm_restore;
        @(posedge core_clk) disable iff (!rstn)
        take && sdoWrite && sdoIndex == 16'h1011 && sdoSubIndex == 8'h02 && sdoWrData == 32'h64616f6c |=>
        commRestorePulse && !sdoAbort && $stable(cur.app);
    endproperty
    a_comm_restore: assert property (p_comm_restore) else $error("comm restore wrong");

    property p_ro_write;
        @(posedge core_clk) disable iff (!rstn)
        take && sdoWrite && sdoIndex inside {16'h1000, 16'h1001, 16'h1008, 16'h1009, 16'h100a, 16'h1018} |=>
        sdoAck && sdoAbort;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write not aborted");

    c_store: cover property (@(posedge core_clk) disable iff (!rstn) nvWrEn ##4 sdoReady);
    c_abort: cover property (@(posedge core_clk) disable iff (!rstn) sdoAck && sdoAbort);
    c_comm_restore: cover property (@(posedge core_clk) disable iff (!rstn) commRestorePulse);
    c_convert: cover property (@(posedge core_clk) disable iff (!rstn) driveParamWr && driveParamSlot == 2'h0);
    c_reload: cover property (@(posedge core_clk) disable iff (!rstn) cur.state == objdict_pkg::ST_RELOAD
                              && nvRdValid);
endmodule : object_dictionary_store_restore

// ### sdo_master.sv
`timescale 1ns/1ps
module sdo_master (
    input wire logic core_clk,
    input wire logic sdoReady,
    input wire logic sdoAck,
    input wire logic sdoAbort,
    input wire logic [31:0] sdoRdData,
    output logic sdoReq,
    output logic sdoWrite,
    output logic [15:0] sdoIndex,
    output logic [7:0] sdoSubIndex,
    output logic [31:0] sdoWrData
);
    initial begin
        sdoReq = 1'b0;
        sdoWrite = 1'b0;
        sdoIndex = 16'hffff;
        sdoSubIndex = 8'hff;
        sdoWrData = 32'h00000000;
    end

    // One whole 32-bit word per request; held until the take edge
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ab, output logic ok);
        int n;
        ok = 1'b0;
        ab = 1'b1;
        rd = 32'h00000000;
        @(posedge core_clk);
        sdoReq <= 1'b1;
        sdoWrite <= w;
        sdoIndex <= idx;
        sdoSubIndex <= sub;
        sdoWrData <= wd;
        #1;
        for (n = 0; n < 40 && sdoReady !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        // Released fields flip so a stale value is never mistaken for a live one
        sdoReq <= 1'b0;
        sdoWrite <= ~w;
        sdoIndex <= ~idx;
        sdoSubIndex <= ~sub;
        sdoWrData <= ~wd;
        #1;
        for (n = 0; n < 2 && sdoAck !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (sdoAck === 1'b1) begin
            ok = 1'b1;
            rd = sdoRdData;
            ab = sdoAbort;
        end
    endtask : xfer
endmodule : sdo_master

// ### object_dictionary_store_restore_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module object_dictionary_store_restore_tb;
    localparam logic [31:0] ID [4] = '{32'h00000b0b, 32'h00000102, 32'h00000003, 32'h00004d21}; // Arbitrary value
    localparam logic [31:0] TXT [3] = '{32'h54494e55, 32'h31305748, 32'h312e3176};
    localparam logic [31:0] SAVE = {8'h65, 8'h76, 8'h61, 8'h73};
    localparam logic [31:0] LOAD = {8'h64, 8'h61, 8'h6f, 8'h6c};
    logic core_clk, rstn, nvEraseN, sdoReq, sdoWrite, sdoReady, sdoAck, sdoAbort, legacyFirmware, deviceFault;
    logic [15:0] sdoIndex;
    logic [7:0] sdoSubIndex, driveSetup, faultCode, pole_pair_count;
    logic [31:0] sdoWrData, sdoRdData, driveParamData;
    logic driveParamWr, commStorePulse, commRestorePulse;
    logic [1:0] driveParamSlot;
    logic [31:0] dpv [4];
    int errors = 0, n_compared = 0, csn = 0, crn = 0;

    sdo_master m_u (.core_clk(core_clk), .sdoReady(sdoReady), .sdoAck(sdoAck), .sdoAbort(sdoAbort),
        .sdoRdData(sdoRdData), .sdoReq(sdoReq), .sdoWrite(sdoWrite), .sdoIndex(sdoIndex),
        .sdoSubIndex(sdoSubIndex), .sdoWrData(sdoWrData));
    object_dictionary_store_restore #(.MAKER_CODE(ID[0]), .PART_CODE(ID[1]), .SYSTEM_REVISION(ID[2]),
        .UNIT_SERIAL(ID[3]), .NAME_TEXT(TXT[0]), .HW_TEXT(TXT[1]), .SW_TEXT(TXT[2])) dut_u (
        .core_clk(core_clk), .rstn(rstn), .nvEraseN(nvEraseN), .sdoReq(sdoReq), .sdoWrite(sdoWrite),
        .sdoIndex(sdoIndex), .sdoSubIndex(sdoSubIndex), .sdoWrData(sdoWrData), .sdoReady(sdoReady),
        .sdoAck(sdoAck), .sdoAbort(sdoAbort), .sdoRdData(sdoRdData), .legacyFirmware(legacyFirmware),
        .driveSetup(driveSetup), .deviceFault(deviceFault), .faultCode(faultCode),
        .pole_pair_count(pole_pair_count), .driveParamWr(driveParamWr), .driveParamSlot(driveParamSlot),
        .driveParamData(driveParamData), .commStorePulse(commStorePulse), .commRestorePulse(commRestorePulse));

    // Pulses last one cycle, so they are caught at every edge
    always @(posedge core_clk) begin
        if (driveParamWr === 1'b1) dpv[driveParamSlot] <= driveParamData;
        if (commStorePulse === 1'b1) csn <= csn + 1;
        if (commRestorePulse === 1'b1) crn <= crn + 1;
    end

    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic xrd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
        logic [31:0] r;
        logic a, k;
        m_u.xfer(1'b0, i, s, 32'h0, r, a, k);
        `CHK("read answer", 2'b10, {k, a})
        `CHK("read data", e, r)
    endtask : xrd

    task automatic xwr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic ab);
        logic [31:0] r;
        logic a, k;
        m_u.xfer(1'b1, i, s, d, r, a, k);
        `CHK("write answer", {1'b1, ab}, {k, a})
    endtask : xwr

    task automatic t_type_fault;
        logic [31:0] r;
        logic a, k;
        @(posedge core_clk);
        legacyFirmware <= 1'b0;
        xrd(objdict_pkg::IDX_DEVICE_TYPE, 8'h00, 32'h002a0192);
        xwr(objdict_pkg::IDX_DEVICE_TYPE, 8'h00, 32'h00000000, 1'b1);
        legacyFirmware <= 1'b1;
        xrd(objdict_pkg::IDX_DEVICE_TYPE, 8'h00, 32'h00290192);
        driveSetup <= 8'h40;
        xrd(objdict_pkg::IDX_DEVICE_TYPE, 8'h00, 32'h002a0192);
        legacyFirmware <= 1'b0;
        xrd(objdict_pkg::IDX_FAULT, 8'h00, 32'h00000000);
        deviceFault <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            faultCode <= c ? 8'h5a : 8'h00;
            m_u.xfer(1'b0, objdict_pkg::IDX_FAULT, 8'h00, 32'h0, r, a, k);
            `CHK("fault nonzero", 1'b1, (r[7:0] != 8'h00) && (r[31:8] == 24'h0))
        end
        deviceFault <= 1'b0;
    endtask : t_type_fault

    task automatic t_tables;
        xrd(objdict_pkg::IDX_STORE, 8'h00, 32'h00000003);
        xrd(objdict_pkg::IDX_RESTORE, 8'h00, 32'h00000003);
        xrd(objdict_pkg::IDX_IDENTITY, 8'h00, 32'h00000004);
        for (int s = 1; s < 4; s++) xrd(objdict_pkg::IDX_STORE, s[7:0], objdict_pkg::STORE_CAPS);
        for (int s = 1; s < 5; s++) xrd(objdict_pkg::IDX_IDENTITY, s[7:0], ID[s-1]);
        xwr(objdict_pkg::IDX_IDENTITY, 8'h01, 32'h00000000, 1'b1);
        xrd(objdict_pkg::IDX_NAME, 8'h00, TXT[0]);
        xrd(objdict_pkg::IDX_HW_VER, 8'h00, TXT[1]);
        xrd(objdict_pkg::IDX_SW_VER, 8'h00, TXT[2]);
        xwr(objdict_pkg::IDX_SW_VER, 8'h00, 32'h00000000, 1'b1);
    endtask : t_tables

    task automatic t_bad_and_restore;
        logic [31:0] bad [3] = '{SAVE, LOAD ^ 32'h00000001, {LOAD[23:0], 8'h00}};
        xwr(16'h6001, 8'h00, 32'h00001234, 1'b0);
        for (int b = 0; b < 3; b++) xwr(objdict_pkg::IDX_RESTORE, 8'h03, bad[b], 1'b1);
        for (int s = 1; s < 4; s++) xwr(objdict_pkg::IDX_STORE, s[7:0], LOAD, 1'b1);
        `CHK("comm pulses after refusals", 64'h0, {csn, crn})
        xrd(16'h6001, 8'h00, 32'h00001234);
        xwr(objdict_pkg::IDX_RESTORE, 8'h02, LOAD, 1'b0);
        xrd(16'h6001, 8'h00, 32'h00001234);
        `CHK("comm restore pulse", 1, crn)
        xwr(objdict_pkg::IDX_RESTORE, 8'h03, LOAD, 1'b0);
        xrd(16'h6001, 8'h00, 32'h00000000);
        xwr(16'h6003, 8'h00, 32'h00000055, 1'b0);
        xwr(objdict_pkg::IDX_RESTORE, 8'h01, LOAD, 1'b0);
        xrd(16'h6003, 8'h00, 32'h00000000);
        `CHK("comm restore pulses", 2, crn)
    endtask : t_bad_and_restore

    // Marks are laid while reset holds, after the last pulse has been caught
    task automatic power_cycle;
        @(posedge core_clk);
        rstn <= 1'b0;
        @(posedge core_clk);
        for (int s = 0; s < 4; s++) dpv[s] = 32'hdeadbeef;
        @(posedge core_clk);
        rstn <= 1'b1;
    endtask : power_cycle

    task automatic t_save_power;
        xwr(16'h6002, 8'h00, 32'h00000077, 1'b0);
        power_cycle();
        xrd(16'h6002, 8'h00, 32'h00000000);
        `CHK("unsaved slot kept off drive", 32'hdeadbeef, dpv[2])
        pole_pair_count <= 8'h04;
        xwr(16'h6000, 8'h00, 32'd1140, 1'b0);
        `CHK("speed to frequency four pairs", 34'h04c, {driveParamSlot, driveParamData})
        pole_pair_count <= 8'h02;
        xwr(16'h6000, 8'h00, 32'd1140, 1'b0);
        `CHK("speed to frequency", 34'h026, {driveParamSlot, driveParamData})
        xwr(16'h6001, 8'h00, 32'h00001234, 1'b0);
        xwr(objdict_pkg::IDX_STORE, 8'h02, SAVE, 1'b0);
        xwr(objdict_pkg::IDX_STORE, 8'h03, SAVE, 1'b0);
        `CHK("comm store pulse", 1, csn)
        xwr(16'h6001, 8'h00, 32'h00009999, 1'b0);
        xwr(16'h6002, 8'h00, 32'h00000077, 1'b0);
        power_cycle();
        xrd(16'h6001, 8'h00, 32'h00001234);
        xrd(16'h6002, 8'h00, 32'h00000000);
        `CHK("reloaded slot 1", 32'h00001234, dpv[1])
        `CHK("reloaded slot 0", 32'h00000026, dpv[0])
        `CHK("reloaded slot 2", 32'h00000000, dpv[2])
        xwr(objdict_pkg::IDX_STORE, 8'h01, SAVE, 1'b0);
        xrd(16'h6001, 8'h00, 32'h00001234);
        `CHK("comm store pulses", 2, csn)
    endtask : t_save_power

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        #(5000 * 25);
        errors++;
        complete_run();
    end

    initial begin
        rstn = 1'b0;
        nvEraseN = 1'b0;
        legacyFirmware = 1'b0;
        driveSetup = 8'h10;
        deviceFault = 1'b0;
        faultCode = 8'h00;
        pole_pair_count = 8'h02;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        nvEraseN <= 1'b1;
        t_type_fault();
        t_tables();
        t_bad_and_restore();
        t_save_power();
        complete_run();
    end
endmodule : object_dictionary_store_restore_tb
